// [pkg/uec_pkg.sv]
// Package for the endpoint count and status register block
`default_nettype none
package uec_pkg;
    // ========================================
    // Register map (byte addresses)
    localparam logic [7:0] UEC_OFF_EP0 = 8'h00;
    localparam logic [7:0] UEC_OFF_EP1 = 8'h04;
    localparam logic [7:0] UEC_OFF_EP2 = 8'h08;
    localparam int UEC_NUM_EP = 3;
    // ========================================
    // Field layout
    localparam int UEC_BIT_TOGGLE = 7;
    localparam int UEC_BIT_VALID = 6;
    localparam int UEC_CNT_MSB = 3;
    localparam logic [7:0] UEC_RESET_VAL = 8'h00;
    localparam logic [7:0] UEC_WR_MASK = 8'hFF;
    localparam logic [3:0] UEC_CRC_BYTES = 4'h2;
    localparam logic [3:0] UEC_MAX_RX_DATA = 4'h8;
    // ========================================
    // AHB-Lite codes
    localparam logic [1:0] UEC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] UEC_HSIZE_WORD = 3'h2;

    // Register contents
    typedef struct packed {
        logic toggle;
        logic valid;
        logic [1:0] rsvd;
        logic [3:0] count;
    } uec_reg_t;

    // Reception report from the interface engine
    typedef struct packed {
        logic done;
        logic [1:0] ep;
        logic toggle;
        logic err;
        logic keep_valid;
        logic [3:0] nbytes;
    } uec_rx_t;

    typedef enum logic [1:0] {
        UEC_ST_IDLE = 2'b00,
        UEC_ST_DATA = 2'b01
    } uec_state_t;
endpackage : uec_pkg
`default_nettype wire

// [hw/uec_ahb_if.sv]
// AHB-Lite slave front end: one-cycle data phase, decoded strobes
`timescale 1ns/1ps
`default_nettype none
module uec_ahb_if import uec_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [7:0] haddr,
    input wire logic hready,
    output logic wr_stb,
    output logic rd_stb,
    output logic [1:0] ep_sel,
    output logic hit
);
    uec_state_t state_reg;
    logic [7:0] addr_reg;
    logic wr_reg;
    wire take = hsel && hready && (htrans == UEC_HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= UEC_ST_IDLE;
            addr_reg <= 8'h00;
            wr_reg <= 1'b0;
        end else begin
            state_reg <= take ? UEC_ST_DATA : UEC_ST_IDLE;
            if (take) begin
                addr_reg <= haddr;
                wr_reg <= hwrite;
            end
        end
    end

    wire in_data = (state_reg == UEC_ST_DATA);
    assign ep_sel = (addr_reg == UEC_OFF_EP1) ? 2'd1 :
                    (addr_reg == UEC_OFF_EP2) ? 2'd2 : 2'd0;
    assign hit = (addr_reg == UEC_OFF_EP0) || (addr_reg == UEC_OFF_EP1) ||
                 (addr_reg == UEC_OFF_EP2);
    assign wr_stb = in_data && wr_reg && hit;
    assign rd_stb = in_data && !wr_reg && hit;
endmodule : uec_ahb_if
`default_nettype wire

// [hw/uec_ep_reg.sv]
// One endpoint count/status register with optional lock
`timescale 1ns/1ps
`default_nettype none
module uec_ep_reg import uec_pkg::*; #(
    parameter bit HAS_LOCK = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    input wire logic hw_upd,
    input wire logic hw_toggle,
    input wire logic hw_err,
    input wire logic hw_keep_valid,
    input wire logic [3:0] hw_nbytes,
    output uec_reg_t q,
    output logic locked
);
    uec_reg_t val_reg;
    uec_reg_t val_next;
    logic lock_reg;
    logic lock_next;
    wire wr_ok = wr_en && !(HAS_LOCK && lock_reg);

    always_comb begin
        val_next = val_reg;
        lock_next = lock_reg;
        if (HAS_LOCK && rd_en) begin
            lock_next = 1'b0;
        end
        if (hw_upd) begin
            val_next.toggle = hw_toggle;
            if (!hw_keep_valid) begin
                val_next.valid = !hw_err;
            end
            val_next.count = hw_nbytes + UEC_CRC_BYTES;
            lock_next = HAS_LOCK;
        end else if (wr_ok) begin
            val_next = uec_reg_t'(wdata & UEC_WR_MASK);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            val_reg <= uec_reg_t'(UEC_RESET_VAL);
            lock_reg <= 1'b0;
        end else begin
            val_reg <= val_next;
            lock_reg <= lock_next;
        end
    end

    assign q = val_reg;
    assign locked = lock_reg;
endmodule : uec_ep_reg
`default_nettype wire

// [hw/uec_top.sv]
// Endpoint count and status registers behind an AHB-Lite slave
//
// Overview of operation
// - Toggle: firmware sets for IN, hardware for OUT
// - Received toggle stored after OUT/SETUP reception
// - Valid cleared on CRC/stuff/PID error, else set
// - Some modes leave valid unchanged
// - Reception done event raised even when invalid
// - Bit7 toggle, bit6 valid, count 3:0, reset 0
// - Received count equals bytes plus two
// - Endpoint 0 locks on hardware update
// - Reading endpoint 0 releases the lock
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module uec_top import uec_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire uec_rx_t rx_in,
    output logic rx_event,
    output logic [7:0] ep0_reg_out,
    output logic ep0_locked
);
    // ========================================
    // Bus front end
    logic wr_stb;
    logic rd_stb;
    logic [1:0] ep_sel;
    logic hit;

    uec_ahb_if u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .htrans(htrans),
        .hwrite(hwrite),
        .haddr(haddr),
        .hready(hready),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .ep_sel(ep_sel),
        .hit(hit)
    );

    // ========================================
    // Endpoint registers
    uec_reg_t q [UEC_NUM_EP];
    logic [UEC_NUM_EP-1:0] lk;
    wire rx_valid_ep = rx_in.done && (rx_in.nbytes <= UEC_MAX_RX_DATA);

    genvar g;
    generate
        for (g = 0; g < UEC_NUM_EP; g++) begin : g_ep
            uec_ep_reg #(.HAS_LOCK(g == 0)) u_ep (
                .hclk(hclk),
                .hresetn(hresetn),
                .wr_en(wr_stb && ep_sel == 2'(g)),
                .rd_en(rd_stb && ep_sel == 2'(g)),
                .wdata(hwdata[7:0]),
                .hw_upd(rx_valid_ep && rx_in.ep == 2'(g)),
                .hw_toggle(rx_in.toggle),
                .hw_err(rx_in.err),
                .hw_keep_valid(rx_in.keep_valid),
                .hw_nbytes(rx_in.nbytes),
                .q(q[g]),
                .locked(lk[g])
            );
        end
    endgenerate

    // ========================================
    // Read data, registered; answer in one data cycle
    wire in_addr = hsel && hready && (htrans == UEC_HTRANS_NONSEQ) && !hwrite;
    wire [1:0] a_sel = (haddr == UEC_OFF_EP1) ? 2'd1 :
                       (haddr == UEC_OFF_EP2) ? 2'd2 : 2'd0;
    wire a_hit = (haddr == UEC_OFF_EP0) || (haddr == UEC_OFF_EP1) ||
                 (haddr == UEC_OFF_EP2);
    wire [7:0] rd_byte = a_hit ? q[a_sel] : 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            rx_event <= 1'b0;
            ep0_reg_out <= 8'h00;
            ep0_locked <= 1'b0;
        end else begin
            if (in_addr) begin
                hrdata <= {24'h00_0000, rd_byte};
            end
            rx_event <= rx_in.done;
            ep0_reg_out <= q[0];
            ep0_locked <= lk[0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ========================================
    // Checks
    property p_lock_set;
        @(posedge hclk) disable iff (!hresetn)
        (rx_valid_ep && rx_in.ep == 2'd0) |=> lk[0];
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("ep0 not locked");

    property p_unlock;
        @(posedge hclk) disable iff (!hresetn)
        (rd_stb && ep_sel == 2'd0 && !(rx_valid_ep && rx_in.ep == 2'd0)) |=> !lk[0];
    endproperty
    a_unlock: assert property (p_unlock) else $error("ep0 lock kept after read");

    wire rd_valid_any = rx_valid_ep;
    property p_locked_wr;
        @(posedge hclk) disable iff (!hresetn)
        (lk[0] && wr_stb && ep_sel == 2'd0 && !rd_valid_any) |=> $stable(q[0]);
    endproperty
    a_locked_wr: assert property (p_locked_wr) else $error("locked ep0 written");

    property p_count;
        @(posedge hclk) disable iff (!hresetn)
        rx_valid_ep |=> q[$past(rx_in.ep)].count == $past(rx_in.nbytes) + 4'd2;
    endproperty
    a_count: assert property (p_count) else $error("count not bytes plus two");

    property p_toggle;
        @(posedge hclk) disable iff (!hresetn)
        rx_valid_ep |=> q[$past(rx_in.ep)].toggle == $past(rx_in.toggle);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle not stored");

    property p_valid;
        @(posedge hclk) disable iff (!hresetn)
        (rx_valid_ep && !rx_in.keep_valid) |=>
            q[$past(rx_in.ep)].valid == !$past(rx_in.err);
    endproperty
    a_valid: assert property (p_valid) else $error("valid flag wrong");

    property p_keep;
        @(posedge hclk) disable iff (!hresetn)
        (rx_valid_ep && rx_in.keep_valid && !(wr_stb && ep_sel == rx_in.ep)) |=>
            q[$past(rx_in.ep)].valid == $past(q[rx_in.ep].valid);
    endproperty
    a_keep: assert property (p_keep) else $error("valid changed in keep mode");

    property p_event;
        @(posedge hclk) disable iff (!hresetn)
        (rx_in.done && rx_in.err) |=> rx_event;
    endproperty
    a_event: assert property (p_event) else $error("event lost on bad data");

    property p_prio;
        @(posedge hclk) disable iff (!hresetn)
        (rx_valid_ep && rx_in.ep == 2'd0 && wr_stb && ep_sel == 2'd0) |=>
            (lk[0] && q[0].count == $past(rx_in.nbytes) + 4'd2);
    endproperty
    a_prio: assert property (p_prio) else $error("write beat hardware update");

    c_rx0: cover property (@(posedge hclk) disable iff (!hresetn) rx_valid_ep && rx_in.ep == 2'd0);
    c_unlock: cover property (@(posedge hclk) disable iff (!hresetn) lk[0] ##1 !lk[0]);
    c_wr: cover property (@(posedge hclk) disable iff (!hresetn) wr_stb && hit);
endmodule : uec_top
`default_nettype wire

// [verif/uec_rx_model.sv]
// Interface engine model that reports OUT and SETUP receptions
`timescale 1ns/1ps
`default_nettype none
module uec_rx_model import uec_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req,
    input wire uec_rx_t cmd,
    output uec_rx_t rx_out
);
    // ========================================
    // Report driver: one-cycle done pulse, fields scrambled between reports
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_out <= '0;
        end else if (req) begin
            rx_out <= cmd;
        end else begin
            rx_out <= {1'b0, ~rx_out[8:0]};
        end
    end
endmodule : uec_rx_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking testbench for the endpoint count and status registers
`timescale 1ns/1ps
`default_nettype none
module tb_top import uec_pkg::*;;
    logic hclk, hresetn, hsel, hwrite, req, hreadyout, hresp, rx_event, ep0_locked, lk;
    logic [7:0] haddr, ep0_reg_out, e;
    logic [7:0] mem [3];
    logic [1:0] htrans, k;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, r;
    uec_rx_t cmd, rx_in;
    int n_errors, compares;
    // ========================================
    // Instances
    uec_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_in(rx_in), .rx_event(rx_event), .ep0_reg_out(ep0_reg_out),
        .ep0_locked(ep0_locked));
    uec_rx_model model_u (.hclk(hclk), .hresetn(hresetn), .req(req), .cmd(cmd),
        .rx_out(rx_in));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // ========================================
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        compares++;
        if (g !== x) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, x);
        end
    endtask : chk
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= UEC_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic wr(input logic [1:0] ep, input logic [7:0] d);
        bus({4'h0, ep, 2'h0}, 1'b1, d);
        if (!(ep == 2'h0 && lk)) mem[ep] = d;
    endtask : wr
    task automatic rdchk(input logic [1:0] ep, input logic [7:0] m);
        bus({4'h0, ep, 2'h0}, 1'b0, 8'h00);
        chk(r & 32'(m), 32'(mem[ep] & m), "read");
        if (ep == 2'h0) lk = 1'b0;
    endtask : rdchk
    task automatic rx(input logic [1:0] ep, input logic t, input logic er, input logic kp,
        input logic [3:0] nb);
        @(posedge hclk);
        req <= 1'b1;
        cmd <= '{1'b1, ep, t, er, kp, nb};
        @(posedge hclk);
        req <= 1'b0;
        @(posedge hclk);
        #1;
        chk(32'(rx_event), 32'h0000_0001, "event");
        if (nb <= UEC_MAX_RX_DATA) begin
            e = {t, kp ? mem[ep][6] : ~er, mem[ep][5:4], nb + UEC_CRC_BYTES};
            mem[ep] = e;
            if (ep == 2'h0) lk = 1'b1;
        end
    endtask : rx
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    // ========================================
    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, req, lk} = '0;
        {haddr, htrans, hwdata, cmd} = '0;
        hsize = UEC_HSIZE_WORD;
        mem = '{8'h00, 8'h00, 8'h00};
        void'($urandom(65731));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(8'h0C, 1'b1, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            bus(8'(i * 4), 1'b0, 8'h00);
            chk(r, 32'h0000_0000, "reset or unmapped");
        end
        chk(32'(hresp), 32'h0000_0000, "resp");
        $display("Test done: reset");
        for (int i = 0; i < 12; i++) begin
            k = 2'($urandom_range(2));
            wr(k, {1'($urandom), 3'($urandom), 4'($urandom_range(8))});
            rdchk(k, 8'hFF);
        end
        $display("Test done: firmware writes");
        for (int i = 0; i < 20; i++) begin
            k = 2'($urandom_range(2));
            rx(k, 1'($urandom), 1'($urandom), 1'($urandom), 4'($urandom_range(8)));
            rdchk(k, 8'hCF);
        end
        rx(2'h1, 1'b1, 1'b1, 1'b1, 4'h8);
        rdchk(2'h1, 8'hCF);
        rx(2'h2, 1'b0, 1'b1, 1'b0, 4'h0);
        rdchk(2'h2, 8'hCF);
        $display("Test done: receptions");
        rx(2'h0, 1'b1, 1'b0, 1'b0, 4'h3);
        @(posedge hclk);
        #1;
        chk(32'(ep0_locked), 32'h0000_0001, "lock");
        chk(32'(ep0_reg_out), 32'(mem[0]), "ep0 copy");
        wr(2'h0, 8'h05);
        rdchk(2'h0, 8'hCF);
        wr(2'h0, 8'h05);
        rdchk(2'h0, 8'hFF);
        fork
            wr(2'h0, 8'h07);
            rx(2'h0, 1'b0, 1'b1, 1'b0, 4'h6);
        join
        wr(2'h0, 8'hFF);
        rdchk(2'h0, 8'hCF);
        $display("Test done: endpoint 0 lock");
        rx(2'h0, 1'b1, 1'b1, 1'b0, 4'h8);
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        #1;
        chk(32'(ep0_locked), 32'h0000_0000, "lock after reset");
        chk(32'(ep0_reg_out), 32'h0000_0000, "ep0 after reset");
        @(posedge hclk);
        hresetn <= 1'b1;
        mem = '{8'h00, 8'h00, 8'h00};
        lk = 1'b0;
        rx(2'h0, 1'b1, 1'b0, 1'b0, 4'hC);
        wr(2'h0, 8'h5A);
        rdchk(2'h0, 8'hFF);
        rdchk(2'h1, 8'hFF);
        $display("Test done: mid-run reset and refused report");
        results();
    end
    initial begin
        repeat (5000) @(posedge hclk);
        n_errors++;
        results();
    end
endmodule : tb_top
`default_nettype wire
